// ---- verilog/uflc_consts.svh ----
`ifndef UFLC_CONSTS_SVH
`define UFLC_CONSTS_SVH
`define UFLC_OFF_DATA   8'h00
`define UFLC_OFF_DIVHI  8'h04
`define UFLC_OFF_FIFO   8'h08
`define UFLC_OFF_LCR    8'h0c
`define UFLC_OFF_MCR    8'h10
`define UFLC_OFF_MSR    8'h18
`define UFLC_OFF_STAT   8'h1c
`define UFLC_LCR_DLAB   7
`define UFLC_LCR_BRK    6
`define UFLC_LCR_STICK  5
`define UFLC_LCR_EPS    4
`define UFLC_LCR_PEN    3
`define UFLC_LCR_STOP   2
`define UFLC_MCR_AFCE   5
`define UFLC_MCR_LOOP   4
`define UFLC_MCR_OUTB   3
`define UFLC_MCR_OUTA   2
`define UFLC_MCR_RTS    1
`define UFLC_MCR_DTR    0
`define UFLC_LCR_RST    8'h00
`define UFLC_MCR_RST    6'h00
`define UFLC_DIV_RST    8'h00
`define UFLC_TICK_HALF  5'h07
`define UFLC_TICK_ONE   5'h0f
`define UFLC_TICK_ONEH  5'h17
`define UFLC_TICK_TWO   5'h1f
`define UFLC_RESP_OKAY  2'h0
`define UFLC_RESP_ERR   2'h2
`endif

// ---- verilog/uflc_pkg.sv ----
package uflc_pkg;
   typedef enum logic [2:0] {
      UFLC_IDLE   = 3'h0,
      UFLC_START  = 3'h1,
      UFLC_DATA   = 3'h3,
      UFLC_PARITY = 3'h2,
      UFLC_STOP   = 3'h6
   } uflc_state_t;
   typedef enum logic [2:0] {
      UFLC_SEL_DATA, UFLC_SEL_DLL, UFLC_SEL_DLH, UFLC_SEL_FIFO,
      UFLC_SEL_LCR, UFLC_SEL_MCR, UFLC_SEL_MSR, UFLC_SEL_NONE
   } uflc_sel_t;
   typedef struct packed {
      logic       stick;
      logic       eps;
      logic       pen;
      logic       stop;
      logic [1:0] wlen;
   } uflc_fmt_t;
endpackage

// ---- verilog/uflc_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface uflc_stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface // uflc_stream_if
`default_nettype wire

// ---- verilog/uflc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module uflc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic     clk,
   input wire logic     rst,
   uflc_stream_if.snk   wr,
   uflc_stream_if.src   rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   wire              full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire              empty = (wp_q == rp_q);
   wire              push  = wr.valid && !full;
   wire              pop   = rd.ready && !empty;
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = mem_q[rp_q[AW-1:0]];
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q[AW-1:0]] <= wr.data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_q + (AW+1)'(push);
         rp_q <= rp_q + (AW+1)'(pop);
      end
   end
endmodule // uflc_fifo
`default_nettype wire

// ---- verilog/uflc_top.sv ----
// Operation
// - line-control bit 7 set exposes divisor low and high bytes for read and write.
// - break bit 6 forces the serial output low until cleared, except in loopback, where the output stays high.
// - stick parity with even-select zero sends and expects parity one.
// - stick parity with even-select one sends and expects parity zero.
// - even-select bit 4 picks even parity when one, odd when zero.
// - parity enable bit 3 turns parity generation and checking on together.
// - stop select zero appends exactly one stop bit.
// - stop select one with five-bit words gives one and a half stop bits.
// - stop select one with six to eight bits gives two stop bits.
// - receiver checks only the first stop bit for framing.
// - length field codes 0 to 3 select 5 to 8 data bits, both directions.
// - loopback holds output high, feeds transmitter to receiver, loops modem lines.
// - user output bits drive their active-low pins inverted, except in loopback, where the pins stay high.
// - auto flow with fifo enabled forces request-to-send inactive above receive threshold.
//
// Register access over AXI4-Lite is this design's own decision.
`include "uflc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module uflc_top (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   input  wire logic        serial_in,
   output logic             serial_out,
   input  wire logic        clear_to_send_n,
   input  wire logic        data_set_ready_n,
   input  wire logic        ring_indicator_n,
   input  wire logic        carrier_detect_n,
   output logic             data_terminal_ready_n,
   output logic             request_to_send_n,
   output logic             user_output_a_pin_n,
   output logic             user_output_b_pin_n
);
   function automatic uflc_pkg::uflc_sel_t dec(input logic [7:0] a, input logic dlab);
      case (a)
         `UFLC_OFF_DATA:  dec = dlab ? uflc_pkg::UFLC_SEL_DLL : uflc_pkg::UFLC_SEL_DATA;
         `UFLC_OFF_DIVHI: dec = dlab ? uflc_pkg::UFLC_SEL_DLH : uflc_pkg::UFLC_SEL_NONE;
         `UFLC_OFF_FIFO:  dec = uflc_pkg::UFLC_SEL_FIFO;
         `UFLC_OFF_LCR:   dec = uflc_pkg::UFLC_SEL_LCR;
         `UFLC_OFF_MCR:   dec = uflc_pkg::UFLC_SEL_MCR;
         `UFLC_OFF_MSR:   dec = uflc_pkg::UFLC_SEL_MSR;
         `UFLC_OFF_STAT:  dec = uflc_pkg::UFLC_SEL_MSR;
         default:         dec = uflc_pkg::UFLC_SEL_NONE;
      endcase
   endfunction
   // parity bit for the character under the given format
   function automatic logic par_bit(input uflc_pkg::uflc_fmt_t f, input logic [7:0] d);
      logic x;
      x = ^(d & (8'hff >> (2'h3 - f.wlen)));
      par_bit = f.stick ? !f.eps : (f.eps ? x : !x);
   endfunction

   logic [7:0]  lcr_q, dll_q, dlh_q, rx_data_q;
   logic [5:0]  mcr_q;
   logic        fifo_en_q, aw_held_q, w_held_q, bvalid_q, rvalid_q;
   logic [7:0]  awaddr_q, wdata_q;
   logic        wstrb0_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [15:0] baud_cnt_q;
   logic        sout_q, loop_bit_q, rx_valid_q, par_err_q, frame_err_q;
   uflc_pkg::uflc_state_t tx_st_q, rx_st_q;
   uflc_pkg::uflc_fmt_t   tx_fmt_q, rx_fmt_q;
   logic [4:0]  tx_cnt_q, rx_cnt_q;
   logic [2:0]  tx_idx_q, rx_idx_q;
   logic [7:0]  tx_sh_q, rx_sh_q;
   logic        tx_par_q, rx_par_q;

   uflc_stream_if #(.W(8)) push_if ();
   uflc_stream_if #(.W(8)) pop_if ();
   // the fifo stalls the bus write response when full, so software never drops a character
   uflc_fifo #(.WIDTH(8), .DEPTH(32)) u_txfifo (
      .clk (clk),
      .rst (rst),
      .wr  (push_if),
      .rd  (pop_if)
   );

   wire        dlab    = lcr_q[`UFLC_LCR_DLAB];
   wire        brk     = lcr_q[`UFLC_LCR_BRK];
   wire        loop    = mcr_q[`UFLC_MCR_LOOP];
   wire uflc_pkg::uflc_fmt_t lcr_fmt = lcr_q[5:0];
   wire uflc_pkg::uflc_sel_t wsel = dec(awaddr_q, dlab);
   wire uflc_pkg::uflc_sel_t rsel = dec(araddr, dlab);
   wire        wr_pend = aw_held_q && w_held_q && !bvalid_q;
   wire        wr_thr  = wr_pend && wsel == uflc_pkg::UFLC_SEL_DATA;
   wire        wr_go   = wr_pend && (!wr_thr || push_if.ready);
   wire        wr_en   = wr_go && wstrb0_q;
   wire        ar_take = arvalid && !rvalid_q;
   wire        rbr_rd  = ar_take && rsel == uflc_pkg::UFLC_SEL_DATA && araddr == `UFLC_OFF_DATA;
   wire [15:0] div_w   = {dlh_q, dll_q};
   wire        tick    = div_w != 16'h0 && baud_cnt_q >= div_w - 16'h1;

   // modem lines as seen internally; loopback feeds outputs back
   wire        cts = loop ? mcr_q[`UFLC_MCR_RTS]  : !clear_to_send_n;
   wire        dsr = loop ? mcr_q[`UFLC_MCR_DTR]  : !data_set_ready_n;
   wire        ri  = loop ? mcr_q[`UFLC_MCR_OUTA] : !ring_indicator_n;
   wire        dcd = loop ? mcr_q[`UFLC_MCR_OUTB] : !carrier_detect_n;
   wire        rx_line = loop ? loop_bit_q : serial_in;
   wire        rts_gate = mcr_q[`UFLC_MCR_AFCE] && fifo_en_q && rx_valid_q;

   assign awready = !aw_held_q;
   assign wready  = !w_held_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = !rvalid_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign push_if.valid = wr_thr && wstrb0_q;
   assign push_if.data  = wdata_q;
   // a waiting character is taken at the last stop tick, so no idle clock stretches the stop bit
   assign pop_if.ready  = tx_st_q == uflc_pkg::UFLC_IDLE || (tx_st_q == uflc_pkg::UFLC_STOP && tx_end);
   assign serial_out    = sout_q;
   // pins go inactive in loopback since the lines are turned inward
   assign data_terminal_ready_n = loop || !mcr_q[`UFLC_MCR_DTR];
   assign request_to_send_n     = loop || !mcr_q[`UFLC_MCR_RTS] || rts_gate;
   assign user_output_a_pin_n   = loop || !mcr_q[`UFLC_MCR_OUTA];
   assign user_output_b_pin_n   = loop || !mcr_q[`UFLC_MCR_OUTB];

   logic [31:0] rd_mux;
   always_comb begin
      case (rsel)
         uflc_pkg::UFLC_SEL_DATA: rd_mux = {24'h0, rx_data_q};
         uflc_pkg::UFLC_SEL_DLL:  rd_mux = {24'h0, dll_q};
         uflc_pkg::UFLC_SEL_DLH:  rd_mux = {24'h0, dlh_q};
         uflc_pkg::UFLC_SEL_FIFO: rd_mux = {31'h0, fifo_en_q};
         uflc_pkg::UFLC_SEL_LCR:  rd_mux = {24'h0, lcr_q};
         uflc_pkg::UFLC_SEL_MCR:  rd_mux = {26'h0, mcr_q};
         uflc_pkg::UFLC_SEL_MSR:  rd_mux = (araddr == `UFLC_OFF_MSR) ? {28'h0, dcd, ri, dsr, cts} :
            {25'h0, tx_st_q == uflc_pkg::UFLC_IDLE && !pop_if.valid, push_if.ready, 1'b0,
             frame_err_q, par_err_q, 1'b0, rx_valid_q};
         default:                 rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `UFLC_RESP_OKAY;
         awaddr_q  <= 8'h00;
         wdata_q   <= 8'h00;
         wstrb0_q  <= 1'b0;
      end else begin
         if (awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= awaddr;
         end else if (wr_go) begin
            aw_held_q <= 1'b0;
         end
         if (wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q  <= wdata[7:0];
            wstrb0_q <= wstrb[0];
         end else if (wr_go) begin
            w_held_q <= 1'b0;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wsel == uflc_pkg::UFLC_SEL_NONE || wsel == uflc_pkg::UFLC_SEL_MSR) ?
                        `UFLC_RESP_ERR : `UFLC_RESP_OKAY;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lcr_q     <= `UFLC_LCR_RST;
         mcr_q     <= `UFLC_MCR_RST;
         dll_q     <= `UFLC_DIV_RST;
         dlh_q     <= `UFLC_DIV_RST;
         fifo_en_q <= 1'b0;
      end else if (wr_en) begin
         case (wsel)
            uflc_pkg::UFLC_SEL_DLL:  dll_q     <= wdata_q;
            uflc_pkg::UFLC_SEL_DLH:  dlh_q     <= wdata_q;
            uflc_pkg::UFLC_SEL_FIFO: fifo_en_q <= wdata_q[0];
            uflc_pkg::UFLC_SEL_LCR:  lcr_q     <= wdata_q;
            uflc_pkg::UFLC_SEL_MCR:  mcr_q     <= wdata_q[5:0];
            default:                 fifo_en_q <= fifo_en_q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= `UFLC_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= (rsel == uflc_pkg::UFLC_SEL_NONE) ? `UFLC_RESP_ERR : `UFLC_RESP_OKAY;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // 16 ticks per bit; a divisor of zero stops the line
   always_ff @(posedge clk) begin
      if (rst || tick || div_w == 16'h0) begin
         baud_cnt_q <= 16'h0;
      end else begin
         baud_cnt_q <= baud_cnt_q + 16'h1;
      end
   end

   logic       tx_frame_bit;
   wire  [4:0] tx_last = (tx_st_q != uflc_pkg::UFLC_STOP || !tx_fmt_q.stop) ? `UFLC_TICK_ONE :
                         (tx_fmt_q.wlen == 2'h0) ? `UFLC_TICK_ONEH : `UFLC_TICK_TWO;
   wire        tx_end  = tick && tx_cnt_q == tx_last;
   always_comb begin
      case (tx_st_q)
         uflc_pkg::UFLC_START:  tx_frame_bit = 1'b0;
         uflc_pkg::UFLC_DATA:   tx_frame_bit = tx_sh_q[0];
         uflc_pkg::UFLC_PARITY: tx_frame_bit = tx_par_q;
         default:               tx_frame_bit = 1'b1;
      endcase
   end
   wire tx_line_d = loop ? 1'b1 : (brk ? 1'b0 : tx_frame_bit);

   always_ff @(posedge clk) begin
      if (rst) begin
         sout_q     <= 1'b1;
         loop_bit_q <= 1'b1;
      end else begin
         sout_q     <= tx_line_d;
         loop_bit_q <= brk ? 1'b0 : tx_frame_bit;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_st_q  <= uflc_pkg::UFLC_IDLE;
         tx_cnt_q <= 5'h0;
         tx_idx_q <= 3'h0;
         tx_sh_q  <= 8'h00;
         tx_par_q <= 1'b0;
         tx_fmt_q <= '0;
      end else if (tx_st_q == uflc_pkg::UFLC_IDLE) begin
         tx_cnt_q <= 5'h0;
         tx_idx_q <= 3'h0;
         if (pop_if.valid) begin
            tx_st_q  <= uflc_pkg::UFLC_START;
            tx_sh_q  <= pop_if.data;
            tx_fmt_q <= lcr_fmt;
            tx_par_q <= par_bit(lcr_fmt, pop_if.data);
         end
      end else if (tick) begin
         tx_cnt_q <= tx_end ? 5'h0 : tx_cnt_q + 5'h1;
         if (tx_end) begin
            case (tx_st_q)
               uflc_pkg::UFLC_START: tx_st_q <= uflc_pkg::UFLC_DATA;
               uflc_pkg::UFLC_DATA: begin
                  tx_sh_q  <= tx_sh_q >> 1;
                  tx_idx_q <= tx_idx_q + 3'h1;
                  if (tx_idx_q == {1'b1, tx_fmt_q.wlen}) begin
                     tx_st_q <= tx_fmt_q.pen ? uflc_pkg::UFLC_PARITY : uflc_pkg::UFLC_STOP;
                  end
               end
               uflc_pkg::UFLC_PARITY: tx_st_q <= uflc_pkg::UFLC_STOP;
               default: begin
                  tx_st_q  <= pop_if.valid ? uflc_pkg::UFLC_START : uflc_pkg::UFLC_IDLE;
                  tx_idx_q <= 3'h0;
                  if (pop_if.valid) begin
                     tx_sh_q  <= pop_if.data;
                     tx_fmt_q <= lcr_fmt;
                     tx_par_q <= par_bit(lcr_fmt, pop_if.data);
                  end
               end
            endcase
         end
      end
   end

   // receiver: start sampled at mid-bit, then one sample per bit
   wire [7:0] rx_align = rx_sh_q >> (2'h3 - rx_fmt_q.wlen);
   wire       rx_samp  = tick && rx_cnt_q == (rx_st_q == uflc_pkg::UFLC_START ? `UFLC_TICK_HALF : `UFLC_TICK_ONE);
   wire       rx_done  = rx_samp && rx_st_q == uflc_pkg::UFLC_STOP;
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_st_q  <= uflc_pkg::UFLC_IDLE;
         rx_cnt_q <= 5'h0;
         rx_idx_q <= 3'h0;
         rx_sh_q  <= 8'h00;
         rx_par_q <= 1'b0;
         rx_fmt_q <= '0;
      end else if (rx_st_q == uflc_pkg::UFLC_IDLE) begin
         rx_cnt_q <= 5'h0;
         rx_idx_q <= 3'h0;
         rx_par_q <= 1'b0;
         if (tick && !rx_line) begin
            rx_st_q  <= uflc_pkg::UFLC_START;
            rx_fmt_q <= lcr_fmt;
         end
      end else if (tick) begin
         rx_cnt_q <= rx_samp ? 5'h0 : rx_cnt_q + 5'h1;
         if (rx_samp) begin
            case (rx_st_q)
               uflc_pkg::UFLC_START: rx_st_q <= rx_line ? uflc_pkg::UFLC_IDLE : uflc_pkg::UFLC_DATA;
               uflc_pkg::UFLC_DATA: begin
                  rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
                  rx_idx_q <= rx_idx_q + 3'h1;
                  if (rx_idx_q == {1'b1, rx_fmt_q.wlen}) begin
                     rx_st_q <= rx_fmt_q.pen ? uflc_pkg::UFLC_PARITY : uflc_pkg::UFLC_STOP;
                  end
               end
               uflc_pkg::UFLC_PARITY: begin
                  rx_par_q <= rx_line != par_bit(rx_fmt_q, rx_align);
                  rx_st_q  <= uflc_pkg::UFLC_STOP;
               end
               default: rx_st_q <= uflc_pkg::UFLC_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_valid_q  <= 1'b0;
         rx_data_q   <= 8'h00;
         par_err_q   <= 1'b0;
         frame_err_q <= 1'b0;
      end else if (rx_done) begin
         rx_valid_q  <= 1'b1;                                          // set beats a same-cycle read
         rx_data_q   <= rx_align;
         par_err_q   <= rx_par_q;
         frame_err_q <= !rx_line;
      end else if (rbr_rd) begin
         rx_valid_q  <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_DLAB_READ: assert property (ar_take && dlab && araddr == `UFLC_OFF_DATA |=> rdata == {24'h0, dll_q})
      else $error("divisor low byte not returned with dlab set");
   AST_BREAK_LOW: assert property (brk && !loop |=> !serial_out)
      else $error("break did not hold the line low");
   AST_STICK_ONE: assert property (tx_st_q == uflc_pkg::UFLC_PARITY && tx_fmt_q.stick && !tx_fmt_q.eps |-> tx_par_q)
      else $error("stick parity with odd select not one");
   AST_STICK_ZERO: assert property (tx_st_q == uflc_pkg::UFLC_PARITY && tx_fmt_q.stick && tx_fmt_q.eps |-> !tx_par_q)
      else $error("stick parity with even select not zero");
   AST_PAR_DATA: assert property (tx_st_q == uflc_pkg::UFLC_START && tx_end && tx_fmt_q.wlen == 2'h3 && !tx_fmt_q.stick
      |-> (^tx_sh_q ^ tx_par_q) == !tx_fmt_q.eps)
      else $error("parity sense wrong for eight data bits");
   AST_DATA_EXIT: assert property (tx_st_q == uflc_pkg::UFLC_DATA && tx_end && tx_idx_q == {1'b1, tx_fmt_q.wlen}
      |=> tx_st_q == (tx_fmt_q.pen ? uflc_pkg::UFLC_PARITY : uflc_pkg::UFLC_STOP))
      else $error("data phase length or parity step wrong");
   AST_ONE_STOP: assert property (tx_st_q == uflc_pkg::UFLC_STOP && !tx_fmt_q.stop && tick && tx_cnt_q == `UFLC_TICK_ONE
      |=> tx_st_q != uflc_pkg::UFLC_STOP)
      else $error("single stop bit too long");
   AST_HALF_STOP: assert property (tx_st_q == uflc_pkg::UFLC_STOP && tx_fmt_q.stop && tx_fmt_q.wlen == 2'h0 && tick
      && tx_cnt_q == `UFLC_TICK_ONEH |=> tx_st_q != uflc_pkg::UFLC_STOP)
      else $error("one and a half stop bits wrong");
   AST_TWO_STOP: assert property (tx_st_q == uflc_pkg::UFLC_STOP && tx_fmt_q.stop && tx_fmt_q.wlen != 2'h0 && tick
      && tx_cnt_q == `UFLC_TICK_ONEH |=> tx_st_q == uflc_pkg::UFLC_STOP)
      else $error("two stop bits cut short");
   AST_FIRST_STOP: assert property (rx_done |=> rx_st_q == uflc_pkg::UFLC_IDLE && rx_valid_q)
      else $error("receiver waited past first stop bit");
   AST_LOOP_HIGH: assert property (loop |=> serial_out && user_output_a_pin_n)
      else $error("loopback left line or pins driven");
   AST_OUTA: assert property (wr_en && wsel == uflc_pkg::UFLC_SEL_MCR && wdata_q[`UFLC_MCR_OUTA]
      && !wdata_q[`UFLC_MCR_LOOP] |=> !user_output_a_pin_n)
      else $error("user output a not inverted onto pin");
   AST_RTS_GATE: assert property (rts_gate |-> request_to_send_n)
      else $error("request to send active above threshold");
   AST_FMT_HOLD: assert property (tx_st_q != uflc_pkg::UFLC_IDLE && $past(tx_st_q) != uflc_pkg::UFLC_IDLE
      && !(tx_st_q == uflc_pkg::UFLC_START && $past(tx_st_q) == uflc_pkg::UFLC_STOP)
      |-> $stable(tx_fmt_q))
      else $error("format changed inside a character");
   AST_RSVD: assert property (ar_take && rsel == uflc_pkg::UFLC_SEL_MCR |=> rdata[31:6] == 26'h0)
      else $error("reserved modem control bits not zero");
   COV_CHAR_OUT: cover property (tx_st_q == uflc_pkg::UFLC_STOP ##1 tx_st_q == uflc_pkg::UFLC_IDLE);
   COV_CHAR_IN: cover property (rx_done);
   COV_FIFO_FULL: cover property (wr_thr && !push_if.ready);
   COV_LOOP_RX: cover property (loop && rx_done);
endmodule // uflc_top
`default_nettype wire

// ---- sim/uflc_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
module uflc_remote (
   input  wire logic clk,
   input  wire logic line_in,
   output var logic  line_out
);
   initial line_out = 1'b1;
   // lsb first, 16 clocks a bit; the last bit is the stop level, so the line idles there
   task automatic send(input logic [11:0] bits, input int cnt);
      for (int i = 0; i < cnt; i++) begin
         line_out <= bits[i];
         repeat (16) @(posedge clk);
      end
   endtask
   // mid-bit samples, then start-to-start spacing to the next character in clocks
   task automatic recv(input int nb, output logic [8:0] got, output int gap);
      realtime t0;
      @(negedge line_in);
      t0 = $realtime;
      repeat (8) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         repeat (16) @(posedge clk);
         got[i] = line_in;
      end
      @(negedge line_in);
      gap = int'(($realtime - t0) / 10.0);
   endtask
endmodule // uflc_remote
`default_nettype wire

// ---- sim/uart_line_format_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module uart_line_format_control_tb;
   logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, serial_in, serial_out, par;
   logic        clear_to_send_n, data_set_ready_n, ring_indicator_n, carrier_detect_n;
   logic        data_terminal_ready_n, request_to_send_n, user_output_a_pin_n, user_output_b_pin_n;
   logic [7:0]  awaddr, araddr, f, dm;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, pins;
   logic [1:0]  bresp, rresp;
   logic [8:0]  got;
   int          fail_count, comparisons, n, sp, gap;
   logic [7:0]  fmt [7] = '{8'h00, 8'h04, 8'h07, 8'h0b, 8'h1a, 8'h29, 8'h3c};
   assign pins = {data_terminal_ready_n, request_to_send_n, user_output_a_pin_n, user_output_b_pin_n};
   uflc_top u_dut (.*);
   uflc_remote u_rem (.clk(clk), .line_in(serial_out), .line_out(serial_in));
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ready and answer are sampled at the falling edge, where they already hold what the next rising edge sees
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] s;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         s = bresp;
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      @(posedge clk);
      cmp(32'(s), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ar, r;
      logic [31:0] d;
      logic [1:0] s;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r = 1'b0;
      while (!r) begin
         @(negedge clk);
         ar = arready;
         r = rvalid;
         d = rdata;
         s = rresp;
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge clk);
      cmp(32'(s), 32'(er));
      if (er == 2'h0) cmp(d, e);
   endtask
   task automatic snd(input logic [7:0] d, input logic bad);
      u_rem.send({1'b1, ^d ^ bad, d, 1'b0}, 11);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #500000;
      fail_count++;
      conclude();
   end
   initial begin
      {rst, wstrb, awvalid, wvalid, bready, arvalid, rready} = 10'h3e0;
      {awaddr, araddr, wdata} = '0;
      {clear_to_send_n, data_set_ready_n, ring_indicator_n, carrier_detect_n} = 4'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h0c, 32'h0, 2'h0);
      rd(8'h10, 32'h0, 2'h0);
      rd(8'h04, 32'h0, 2'h2);
      rd(8'h20, 32'h0, 2'h2);
      wr(8'h0c, 32'h80, 2'h0);
      wr(8'h00, 32'h01, 2'h0);
      wr(8'h04, 32'h00, 2'h0);
      rd(8'h00, 32'h01, 2'h0);
      wr(8'h0c, 32'hffff_ff1f, 2'h0);
      rd(8'h0c, 32'h1f, 2'h0);
      rd(8'h04, 32'h0, 2'h2);
      wr(8'h10, 32'hffff_ffcf, 2'h0);
      rd(8'h10, 32'h0f, 2'h0);
      cmp(32'(pins), 32'h0);
      wr(8'h10, 32'h1f, 2'h0);
      cmp(32'(pins), 32'hf);
      rd(8'h18, 32'hf, 2'h0);
      wr(8'h0c, 32'h03, 2'h0);
      wr(8'h00, 32'h96, 2'h0);
      repeat (40) @(posedge clk);
      cmp(32'(serial_out), 32'h1);
      repeat (200) @(posedge clk);
      rd(8'h00, 32'h96, 2'h0);
      wr(8'h10, 32'h10, 2'h0);
      rd(8'h18, 32'h0, 2'h0);
      wr(8'h10, 32'h0, 2'h0);
      rd(8'h18, 32'hf, 2'h0);
      for (int i = 0; i < 7; i++) begin
         f = fmt[i];
         n = 5 + int'(f[1:0]);
         dm = (8'ha5 ^ 8'(i)) & (8'hff >> (8 - n));
         par = f[5] ? ~f[4] : (f[4] ? ^dm : ~^dm);
         sp = f[2] ? (n == 5 ? 24 : 32) : 16;
         wr(8'h0c, 32'(f), 2'h0);
         fork
            u_rem.recv(n + int'(f[3]), got, gap);
            begin
               wr(8'h00, 32'(dm), 2'h0);
               wr(8'h00, 32'(dm), 2'h0);
            end
         join
         cmp(32'(got[7:0] & (8'hff >> (8 - n))), 32'(dm));
         if (f[3]) cmp(32'(got[n]), 32'(par));
         cmp(32'(gap), 32'(16 * (1 + n + int'(f[3])) + sp));
         repeat (250) @(posedge clk);
      end
      wr(8'h0c, 32'h43, 2'h0);
      repeat (60) @(posedge clk);
      cmp(32'(serial_out), 32'h0);
      wr(8'h0c, 32'h1f, 2'h0);
      repeat (20) @(posedge clk);
      cmp(32'(serial_out), 32'h1);
      wr(8'h08, 32'h1, 2'h0);
      wr(8'h10, 32'h22, 2'h0);
      cmp(32'(request_to_send_n), 32'h0);
      snd(8'h5a, 1'b0);
      snd(8'hc3, 1'b0);
      repeat (20) @(posedge clk);
      cmp(32'(request_to_send_n), 32'h1);
      rd(8'h1c, 32'h61, 2'h0);
      rd(8'h00, 32'hc3, 2'h0);
      cmp(32'(request_to_send_n), 32'h0);
      snd(8'h0f, 1'b1);
      repeat (20) @(posedge clk);
      rd(8'h1c, 32'h65, 2'h0);
      rd(8'h00, 32'h0f, 2'h0);
      conclude();
   end
endmodule // uart_line_format_control_tb
`default_nettype wire
